// File: rtl/sfpp_top.sv
// Serial flash programming port: link decoder, page loader, self-timed sequencer, AHB regs
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: program only while reset and strap high
// RULE2: enable instruction needed before any operation; here reads need no enable
// RULE3: every page write erases its sector itself
// RULE4: chip erase fills both arrays with FFH
// RULE5: code and data use separate address spaces
// RULE6: programmer keeps shift clock slow enough
// RULE7: busy poll returns inverted written bit 7
// RULE8: busy reads toggle bit 6 each time
// RULE9: busy pin low while programming runs
// RULE10: programmer loads whole sector, else indeterminate
// RULE11: sector erased to FFH before programming
// RULE12: loaded bytes programmed together after loading
// RULE13: load gap timeout starts programming
// RULE14: sector address repeated, low bits pick byte
// RULE15: bytes load in any order
// RULE16: reads return polling status while busy
// RULE17: readback only with both locks unprogrammed
// RULE18: lock bits never read back directly
// RULE19: code read frame, byte out last
// RULE20: code write frame, data byte last
// RULE21: chip erase opcode clears both arrays
// RULE22: lock one refuses writes, both refuse reads
// RULE23: only chip erase clears lock bits; here reset_n_i also clears both
// RULE24: MSB first, sample rise, drive fall
// RULE25: write and erase ignored while busy
module sfpp_top #(
  parameter logic [sfpp_pkg::TMR_W-1:0] WC_CYCLES = sfpp_pkg::TMR_W'(sfpp_pkg::WC_CYC),
  parameter logic [sfpp_pkg::TMR_W-1:0] LOAD_CYCLES = sfpp_pkg::TMR_W'(sfpp_pkg::LOAD_CYC)
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic prog_reset_i,
  input wire logic programming_strap_i,
  input wire logic sck_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic busy_indicator_n_o,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic [31:0] hrdata_o,
  output logic hresp_o
);
  import sfpp_pkg::*;

  typedef struct packed {
    sfpp_state_t st; // Sequencer state
    logic en; // Enable instruction seen
    logic [4:0] bc; // Bit within frame
    logic [31:0] sh; // Received bits
    logic [7:0] osh; // Outgoing byte
    logic serial_out; // Serial output level
    logic sck_d; // Previous shift clock
    logic rd_op; // Frame is a read
    logic [16:0] ra; // Read address
    logic ra_dat; // Read targets data array
    logic lb1; // Lock bit one
    logic lb2; // Lock bit two
    logic sect_dat; // Loaded sector is data array
    logic [9:0] sect; // Loaded sector number
    logic [127:0] ld; // Bytes loaded in sector
    logic [7:0] last; // Last byte written
    logic tgl; // Alternating bit
    logic [16:0] sw; // Sweep address
    logic sw_done; // Sweep finished
    logic busy_n; // Busy pin level
    logic ph_w; // Data phase writes control
    logic [31:0] hrdata; // Read data
    logic hready; // Ready out
    logic hresp; // Response
  } sfpp_st_t;

  sfpp_st_t s; // State
  sfpp_st_t n; // Next state

  logic [7:0] code_mem [0:CODE_DEPTH-1]; // Code array
  logic [7:0] data_mem [0:DATA_DEPTH-1]; // Data array
  logic [7:0] page_buf [0:127]; // Sector load buffer
  logic [7:0] code_q; // Registered code read
  logic [7:0] data_q; // Registered data read
  logic rst_q, strap_q, sck_q, sdi_q; // Synchronised pins
  logic prog, sck_rise, sck_fall, frm; // Link events
  logic [31:0] sh_n; // Frame with new bit
  logic [16:0] wa; // Frame address
  logic is_ena, is_era, wr_op, same_sect; // Frame decode
  logic busy, poll_ld, chip_end; // Sequencer events
  logic lt_load, wt_load, lt_run, wt_run; // Timers
  logic mw_code, mw_data, mw_wide, pb_we; // Write strobes, wide for chip erase
  logic [16:0] mw_addr; // Array write address
  logic [7:0] mw_byte, rd_byte, poll; // Bytes
  logic sel; // AHB address phase taken

  // Byte address from the first three frame bytes
  function automatic logic [16:0] f_addr(input logic [23:0] b);
    if (b[23])
      f_addr = {b[16], b[15:0]};
    else
      f_addr = {5'h00, b[11:0]};
  endfunction

  // Opcode match, bit 0 of byte one is address or don't care
  function automatic logic f_op(input logic [7:0] b, input logic [6:0] op);
    f_op = (b[7:1] == op);
  endfunction

  // Pin synchroniser
  sfpp_sync #(.W(4)) u_sync (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .d_i({prog_reset_i, programming_strap_i, sck_i, serial_in_i}),
    .q_o({rst_q, strap_q, sck_q, sdi_q})
  );

  // Byte load gap timer
  sfpp_timer u_load_tmr (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .load_i(lt_load),
    .value_i(LOAD_CYCLES),
    .run_o(lt_run)
  );

  // Self-timed cycle timer
  sfpp_timer u_wc_tmr (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .load_i(wt_load),
    .value_i(WC_CYCLES),
    .run_o(wt_run)
  );

  // Next state of link, sequencer and bus slave
  always_comb
  begin
    n = s;
    lt_load = 1'b0;
    wt_load = 1'b0;
    mw_code = 1'b0;
    mw_data = 1'b0;
    mw_wide = 1'b0;
    mw_addr = '0;
    mw_byte = ERASED;
    pb_we = 1'b0;
    chip_end = 1'b0;
    prog = rst_q & strap_q;
    sck_rise = sck_q & ~s.sck_d;
    sck_fall = ~sck_q & s.sck_d;
    n.sck_d = sck_q;
    sh_n = {s.sh[30:0], sdi_q};
    frm = prog & sck_rise & (s.bc == BC_LAST);
    wa = f_addr(sh_n[31:8]);
    is_ena = (sh_n[31:24] == ENA_B1) && (sh_n[23:16] == ENA_B2)
      && (sh_n[15:8] == ENA_B34) && (sh_n[7:0] == ENA_B34);
    is_era = (sh_n[31:24] == ENA_B1) && (sh_n[23:16] == ERA_B2);
    wr_op = f_op(sh_n[31:24], OP_WR_CODE) | f_op(sh_n[31:24], OP_WR_DATA);
    same_sect = (s.sect == wa[16:7]) && (s.sect_dat == sh_n[31]); // [RULE14]
    busy = (s.st == S_PAGE) || (s.st == S_CHIP);
    poll = {~s.last[7], s.tgl, s.last[5:0]}; // [RULE7] [RULE8]
    // Read answer: status while busy, nothing when locked
    if (busy)
      rd_byte = poll; // [RULE16]
    else if (s.lb1 | s.lb2)
      rd_byte = LOCKED_RD; // [RULE17] [RULE22] [RULE18]
    else
      rd_byte = s.ra_dat ? data_q : code_q; // [RULE5]
    poll_ld = prog & sck_fall & (s.bc == BC_DATA) & s.rd_op & busy;
    // Serial link, only alive in programming mode
    if (!prog)
    begin
      n.en = 1'b0; // [RULE1]
      n.bc = '0;
      n.serial_out = 1'b0;
      n.rd_op = 1'b0;
    end
    else if (sck_rise)
    begin
      // Sample on rising edge, MSB first
      n.sh = sh_n; // [RULE24]
      n.bc = s.bc + 1'b1;
      if (s.bc == BC_ADDR)
      begin
        // Address complete: fetch for a read
        n.rd_op = f_op(sh_n[23:16], OP_RD_CODE) | f_op(sh_n[23:16], OP_RD_DATA); // [RULE19]
        n.ra = f_addr(sh_n[23:0]);
        n.ra_dat = sh_n[23];
      end
      else if (s.bc == BC_LAST)
        n.rd_op = 1'b0;
    end
    else if (sck_fall)
    begin
      // Drive on falling edge
      if (s.bc == BC_DATA && s.rd_op)
      begin
        n.serial_out = rd_byte[7]; // [RULE24]
        n.osh = {rd_byte[6:0], 1'b0};
        if (busy)
          n.tgl = ~s.tgl; // [RULE8]
      end
      else if (s.bc > BC_DATA)
      begin
        n.serial_out = s.osh[7];
        n.osh = {s.osh[6:0], 1'b0};
      end
    end
    // Whole frame received
    if (frm)
    begin
      if (is_ena)
        n.en = 1'b1; // [RULE2]
      else if (s.en && is_era && s.st == S_IDLE)
      begin
        // Start chip erase of both arrays
        n.st = S_CHIP; // [RULE21] [RULE25]
        n.sw = '0;
        n.sw_done = 1'b0;
        n.last = ERASED;
        wt_load = 1'b1;
      end
      else if (s.en && wr_op && !s.lb1
        && (s.st == S_IDLE || (s.st == S_LOAD && same_sect))) // [RULE22] [RULE25]
      begin
        // Buffer the byte at any offset of the sector
        pb_we = 1'b1; // [RULE15] [RULE20]
        n.ld = (s.st == S_IDLE) ? '0 : s.ld;
        n.ld[wa[6:0]] = 1'b1; // [RULE14]
        n.last = sh_n[7:0];
        n.sect = wa[16:7];
        n.sect_dat = sh_n[31];
        n.st = S_LOAD;
        lt_load = 1'b1; // [RULE13]
      end
    end
    // Sequencer
    unique case (s.st)
      S_IDLE:
      begin
      end
      S_LOAD:
      begin
        // Gap timer ran out: program the sector
        if (!lt_run && !lt_load)
        begin
          n.st = S_PAGE; // [RULE13] [RULE12]
          n.sw = '0;
          n.sw_done = 1'b0;
          wt_load = 1'b1;
        end
      end
      S_PAGE:
      begin
        if (!s.sw_done)
        begin
          // Erase and program each byte of the sector in one sweep
          mw_addr = {s.sect, s.sw[6:0]};
          mw_byte = s.ld[s.sw[6:0]] ? page_buf[s.sw[6:0]] : ERASED; // [RULE3] [RULE11] [RULE10]
          mw_code = ~s.sect_dat; // [RULE12]
          mw_data = s.sect_dat;
          n.sw = s.sw + 1'b1;
          n.sw_done = (s.sw[6:0] == SECT_LAST);
        end
        else if (!wt_run)
          n.st = S_IDLE; // [RULE7]
      end
      S_CHIP:
      begin
        if (!s.sw_done)
        begin
          // Fill both arrays with the erased value, four bytes a cycle
          mw_addr = s.sw;
          mw_byte = ERASED; // [RULE4]
          mw_data = 1'b1;
          mw_wide = 1'b1;
          mw_code = (s.sw[16:12] == 5'h00);
          n.sw = s.sw + 17'h00004;
          n.sw_done = ({s.sw[16:2], 2'h3} == DATA_LAST);
        end
        else if (!wt_run)
        begin
          chip_end = 1'b1;
          n.st = S_IDLE;
          n.lb1 = 1'b0; // [RULE23]
          n.lb2 = 1'b0;
        end
      end
      default:
        n.st = S_IDLE;
    endcase
    n.busy_n = ~((n.st == S_PAGE) || (n.st == S_CHIP)); // [RULE9]
    // AHB data phase: setting a lock bit wins over the erase clear
    if (s.ph_w)
    begin
      n.lb1 = n.lb1 | hwdata_i[CTRL_LB1];
      n.lb2 = n.lb2 | hwdata_i[CTRL_LB2];
    end
    // AHB address phase
    sel = hsel_i & htrans_i[1] & hready_i;
    n.ph_w = sel & hwrite_i & (haddr_i == REG_CTRL);
    n.hrdata = '0;
    if (sel && !hwrite_i && haddr_i == REG_STATUS)
    begin
      n.hrdata[ST_EN] = s.en;
      n.hrdata[ST_LOAD] = (s.st == S_LOAD);
      n.hrdata[ST_BUSY] = busy;
      n.hrdata[ST_CHIP] = (s.st == S_CHIP);
    end
    n.hready = 1'b1;
    n.hresp = 1'b0;
  end

  // State register
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s <= '0;
      s.st <= S_IDLE;
      s.busy_n <= 1'b1;
      s.hready <= 1'b1;
    end
    else
      s <= n;
  end

  // Arrays, load buffer and registered array reads
  always_ff @(posedge mclk_i)
  begin
    if (mw_code)
      code_mem[mw_addr[11:0]] <= mw_byte;
    if (mw_data)
      data_mem[mw_addr] <= mw_byte;
    // Chip erase also clears the three neighbours of each swept byte
    for (int k = 1; k < 4; k++)
    begin
      if (mw_wide && mw_code)
        code_mem[{mw_addr[11:2], 2'(k)}] <= mw_byte; // [RULE4]
      if (mw_wide && mw_data)
        data_mem[{mw_addr[16:2], 2'(k)}] <= mw_byte; // [RULE4]
    end
    if (pb_we)
      page_buf[wa[6:0]] <= sh_n[7:0];
    code_q <= code_mem[s.ra[11:0]];
    data_q <= data_mem[s.ra];
  end

  assign serial_out_o = s.serial_out;
  assign busy_indicator_n_o = s.busy_n;
  assign hreadyout_o = s.hready;
  assign hrdata_o = s.hrdata;
  assign hresp_o = s.hresp;

  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_prog_gate;
    !prog |=> !s.en;
  endproperty
  a_prog_gate: assert property (p_prog_gate) else $error("enabled outside programming mode"); // [RULE1]

  property p_need_enable;
    frm && !s.en && !is_ena |=> s.st == $past(s.st) && !s.en;
  endproperty
  a_need_enable: assert property (p_need_enable) else $error("operation before enable"); // [RULE2]

  property p_lock_refuse;
    frm && s.lb1 && wr_op && s.st == S_IDLE |=> s.st == S_IDLE;
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("write taken while locked"); // [RULE22]

  property p_busy_pin;
    busy |-> !busy_indicator_n_o ##1 (busy || busy_indicator_n_o);
  endproperty
  a_busy_pin: assert property (p_busy_pin) else $error("busy pin wrong"); // [RULE9]

  property p_poll_d7;
    poll_ld && s.st == S_PAGE |=> serial_out_o == !s.last[7];
  endproperty
  a_poll_d7: assert property (p_poll_d7) else $error("poll bit 7 not inverted"); // [RULE7]

  property p_toggle;
    poll_ld |=> s.tgl != $past(s.tgl) && serial_out_o == !s.last[7];
  endproperty
  a_toggle: assert property (p_toggle) else $error("bit 6 did not alternate"); // [RULE8]

  property p_busy_ignore;
    frm && busy |=> s.st != S_LOAD && s.st != S_IDLE || $past(s.sw_done);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("frame taken while busy"); // [RULE25]

  property p_load_timeout;
    s.st == S_LOAD && !lt_run && !lt_load |=> s.st == S_PAGE ##1 !busy_indicator_n_o;
  endproperty
  a_load_timeout: assert property (p_load_timeout) else $error("load timeout missed"); // [RULE13]

  property p_erase_unlock;
    chip_end && !s.ph_w |=> !s.lb1 && !s.lb2 && s.st == S_IDLE;
  endproperty
  a_erase_unlock: assert property (p_erase_unlock) else $error("locks kept after erase"); // [RULE23]

  property p_fill_ff;
    s.st == S_PAGE && !s.sw_done && !s.ld[s.sw[6:0]] |-> mw_byte == ERASED;
  endproperty
  a_fill_ff: assert property (p_fill_ff) else $error("unloaded byte not erased"); // [RULE11]

  c_page: cover property (s.st == S_LOAD ##1 s.st == S_PAGE);
  c_chip: cover property (chip_end);
  c_poll: cover property (poll_ld);
endmodule // sfpp_top
`default_nettype wire

// File: rtl/sfpp_pkg.sv
// Shared constants, opcodes, register map and state codes of the serial flash programming port
package sfpp_pkg;
  // Clock rate and self-timed intervals
  localparam int CLK_MHZ = 100;
  localparam int WC_TIME_US = 5000; // Write cycle time, 5 ms
  localparam int WC_CYC = WC_TIME_US * CLK_MHZ;
  localparam int LOAD_TIME_US = 300; // Gap allowed between loaded bytes
  localparam int LOAD_CYC = LOAD_TIME_US * CLK_MHZ;
  localparam int TMR_W = 19; // Timer width, holds WC_CYC
  // Serial frame bit positions
  localparam logic [4:0] BC_ADDR = 5'h17; // Last address bit of a frame
  localparam logic [4:0] BC_DATA = 5'h18; // Data byte starts
  localparam logic [4:0] BC_LAST = 5'h1F; // Last bit of a frame
  // Instruction bytes
  localparam logic [7:0] ENA_B1 = 8'hAC;
  localparam logic [7:0] ENA_B2 = 8'h53;
  localparam logic [7:0] ENA_B34 = 8'hFF;
  localparam logic [7:0] ERA_B2 = 8'h80;
  localparam logic [6:0] OP_RD_CODE = 7'h10;
  localparam logic [6:0] OP_WR_CODE = 7'h20;
  localparam logic [6:0] OP_RD_DATA = 7'h50;
  localparam logic [6:0] OP_WR_DATA = 7'h60;
  // Array geometry and fill values
  localparam int CODE_DEPTH = 4096;
  localparam int DATA_DEPTH = 131072;
  localparam logic [16:0] DATA_LAST = 17'h1FFFF;
  localparam logic [6:0] SECT_LAST = 7'h7F;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] LOCKED_RD = 8'h00;
  // Register map, byte addresses
  localparam logic [31:0] REG_CTRL = 32'h0000_0000;
  localparam logic [31:0] REG_STATUS = 32'h0000_0004;
  localparam int CTRL_LB1 = 0;
  localparam int CTRL_LB2 = 1;
  localparam int ST_EN = 0;
  localparam int ST_LOAD = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_CHIP = 3;
  // Sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_LOAD = 4'h2,
    S_PAGE = 4'h4,
    S_CHIP = 4'h8
  } sfpp_state_t;
endpackage

// File: rtl/sfpp_sync.sv
// Two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sfpp_sync #(
  parameter int W = 4
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // Meta stage feeds only the second stage
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sfpp_sync_t;

  sfpp_sync_t s_r; // State
  sfpp_sync_t s_nxt; // Next state

  // Shift pins through both stages
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.meta = d_i;
    s_nxt.q = s_r.meta;
  end

  // State register
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign q_o = s_r.q;
endmodule // sfpp_sync
`default_nettype wire

// File: rtl/sfpp_timer.sv
// Down counter that runs for a loaded number of cycles
`timescale 1ns/1ps
`default_nettype none
module sfpp_timer (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic load_i,
  input wire logic [sfpp_pkg::TMR_W-1:0] value_i,
  output logic run_o
);
  import sfpp_pkg::*;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic run;
  } sfpp_tmr_t;

  sfpp_tmr_t s_r; // State
  sfpp_tmr_t s_nxt; // Next state

  // Load restarts, otherwise count down to zero
  always_comb
  begin
    s_nxt = s_r;
    if (load_i)
    begin
      s_nxt.cnt = value_i;
      s_nxt.run = 1'b1;
    end
    else if (s_r.run)
    begin
      s_nxt.cnt = s_r.cnt - 1'b1;
      s_nxt.run = (s_r.cnt > 1);
    end
  end

  // State register
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign run_o = s_r.run;
endmodule // sfpp_timer
`default_nettype wire

// File: tb/sfpp_prog_model.sv
// Serial programmer model that shifts four-byte frames into the port
`timescale 1ns/1ps
`default_nettype none
module sfpp_prog_model (
  input wire logic mclk_i,
  input wire logic serial_out_i,
  output logic sck_o,
  output logic serial_in_o
);
  // Shift clock rests low between frames
  initial
  begin
    sck_o = 1'b0;
    serial_in_o = 1'b0;
  end
  // One frame, MSB first; reply bits are taken at the end of each high phase
  task automatic frame(input logic [31:0] f, output logic [7:0] rd);
    for (int i = 31; i >= 0; i--)
    begin
      @(posedge mclk_i);
      if (i < 7)
        rd[i + 1] = serial_out_i; // Stands until this fall
      sck_o <= 1'b0;
      serial_in_o <= f[i];
      repeat (4) @(posedge mclk_i); // Low phase, four cycles
      sck_o <= 1'b1;
      repeat (3) @(posedge mclk_i); // High phase, four cycles
    end
    @(posedge mclk_i);
    rd[0] = serial_out_i;
    sck_o <= 1'b0;
    serial_in_o <= ~f[0]; // Released line shows the inverse of the last bit
  endtask
endmodule // sfpp_prog_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the serial flash programming port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sfpp_pkg::*;
  localparam int LOADC = 400; // Load gap, longer than one 256-cycle frame
  localparam int WCC = 2000; // Write cycle, room for polls while busy
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic prog_reset = 1'b1;
  logic strap = 1'b1;
  logic sck, serial_in, serial_out, busy_n, hreadyout, hresp;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, st;
  logic [7:0] rb, p1, p2;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  // Design with shortened self-timed counts
  sfpp_top #(.WC_CYCLES(TMR_W'(WCC)), .LOAD_CYCLES(TMR_W'(LOADC))) dut_u (
    .mclk_i(mclk), .reset_n_i(reset_n), .prog_reset_i(prog_reset),
    .programming_strap_i(strap), .sck_i(sck), .serial_in_i(serial_in), .serial_out_o(serial_out),
    .busy_indicator_n_o(busy_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hreadyout_o(hreadyout), .hrdata_o(hrdata), .hresp_o(hresp));
  // Programmer on the serial side
  sfpp_prog_model prog_u (.mclk_i(mclk), .serial_out_i(serial_out), .sck_o(sck), .serial_in_o(serial_in));
  // 100 MHz clock
  always #5 mclk = ~mclk;
  // Verdict and end of run
  task automatic final_report();
    if (bad_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      bad_count++;
      final_report();
    end
  end
  // Word compare
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Byte compare, also used for single pins
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // AHB single write: address phase until ready, then data phase until ready
  task automatic ahb_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= 1'b1;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask
  // AHB single read, data taken at the closing ready edge
  task automatic ahb_rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= 1'b0;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  // Status register compare
  task automatic chk_st(input logic [31:0] exp);
    ahb_rd(REG_STATUS, st);
    chk_word(st, exp);
  endtask
  // Serial frames for the code array and the enable instruction
  task automatic cw(input logic [11:0] a, input logic [7:0] d);
    prog_u.frame({OP_WR_CODE, 1'b0, 4'h0, a, d}, rb);
  endtask
  task automatic cr(input logic [11:0] a, output logic [7:0] d);
    prog_u.frame({OP_RD_CODE, 1'b0, 4'h0, a, 8'h00}, d);
  endtask
  task automatic enable();
    prog_u.frame({ENA_B1, ENA_B2, ENA_B34, ENA_B34}, rb);
  endtask
  // Wait for the busy pin to reach a level within a bound, then compare it
  task automatic wait_busy(input logic lvl, input int bound);
    int n;
    n = 0;
    while (busy_n !== lvl && n < bound)
    begin
      @(posedge mclk);
      n++;
    end
    chk_byte({7'h00, busy_n}, {7'h00, lvl});
  endtask
  // Reset pulse, then settle past the pin synchronisers
  task automatic do_reset();
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask
  // Idle state after reset; a write frame refused before enable
  task automatic t_idle();
    chk_byte({5'h00, hresp, busy_n, serial_out}, 8'h02);
    chk_st(32'h0000_0000);
    cw(12'h105, 8'h11);
    chk_st(32'h0000_0000);
    enable();
    chk_st(32'h0000_0001);
  endtask
  // Out-of-order sector load, timeout, polling, busy refusal, readback
  task automatic t_page();
    cw(12'h105, 8'hA5);
    cw(12'h100, 8'h3C);
    cw(12'h17F, 8'hC3);
    chk_byte({7'h00, busy_n}, 8'h01);
    chk_st(32'h0000_0003);
    wait_busy(1'b0, LOADC + 50);
    chk_st(32'h0000_0005);
    cr(12'h105, p1);
    chk_byte({p1[7], 1'b0, p1[5:0]}, 8'h03);
    cr(12'h17F, p2);
    chk_byte({7'h00, p1[6] ^ p2[6]}, 8'h01);
    cw(12'h101, 8'h5A);
    wait_busy(1'b1, WCC + 200);
    chk_st(32'h0000_0001);
    cr(12'h105, rb);
    chk_byte(rb, 8'hA5);
    cr(12'h100, rb);
    chk_byte(rb, 8'h3C);
    cr(12'h17F, rb);
    chk_byte(rb, 8'hC3);
    cr(12'h101, rb);
    chk_byte(rb, ERASED);
  endtask
  // Data array write at the same low address leaves the code byte alone
  task automatic t_data();
    prog_u.frame({OP_WR_DATA, 17'h10105, 8'h3C}, rb);
    wait_busy(1'b0, LOADC + 50);
    wait_busy(1'b1, WCC + 200);
    prog_u.frame({OP_RD_DATA, 17'h10105, 8'h00}, rb);
    chk_byte(rb, 8'h3C);
    cr(12'h105, rb);
    chk_byte(rb, 8'hA5);
  endtask
  // Lock bits: reads refused, then writes refused; no readout; unmapped place
  task automatic t_lock();
    ahb_wr(REG_CTRL, 32'h0000_0002);
    cr(12'h105, rb);
    chk_byte(rb, LOCKED_RD);
    ahb_wr(REG_CTRL, 32'h0000_0001);
    cw(12'h105, 8'h00);
    chk_st(32'h0000_0001);
    ahb_rd(REG_CTRL, st);
    chk_word(st, 32'h0000_0000);
    ahb_wr(32'h0000_0008, 32'hFFFF_FFFF);
    ahb_rd(32'h0000_0008, st);
    chk_word(st, 32'h0000_0000);
  endtask
  // Programming pins drop enable; chip erase is busy, refuses writes, then clears arrays and locks
  task automatic t_chip();
    do_reset();
    enable();
    cr(12'h105, rb);
    chk_byte(rb, 8'hA5);
    prog_reset <= 1'b0;
    repeat (5) @(posedge mclk);
    chk_st(32'h0000_0000);
    prog_reset <= 1'b1;
    strap <= 1'b0;
    repeat (5) @(posedge mclk);
    chk_st(32'h0000_0000);
    strap <= 1'b1;
    repeat (5) @(posedge mclk);
    enable();
    ahb_wr(REG_CTRL, 32'h0000_0003);
    prog_u.frame({ENA_B1, ERA_B2, 8'hFF, 8'hFF}, rb);
    wait_busy(1'b0, 50);
    chk_st(32'h0000_000D);
    cr(12'h000, p1);
    cr(12'h000, p2);
    chk_byte({7'h00, p1[6] ^ p2[6]}, 8'h01);
    cw(12'h000, 8'h00);
    chk_st(32'h0000_000D);
    wait_busy(1'b1, 34000);
    chk_st(32'h0000_0001);
    cr(12'h105, rb);
    chk_byte(rb, ERASED);
    prog_u.frame({OP_RD_DATA, 17'h10105, 8'h00}, rb);
    chk_byte(rb, ERASED);
    cw(12'h000, 8'h00);
    chk_st(32'h0000_0003);
  endtask
  // Main sequence
  initial
  begin
    do_reset();
    t_idle();
    t_page();
    t_data();
    t_lock();
    t_chip();
    final_report();
  end
endmodule // tb_top
`default_nettype wire
